// file: src/adapter_sense_check_monitor.sv
// Sense, check and manual test control logic of the test and monitor adapter
`timescale 1ns/1ps
module adapter_sense_check_monitor
  import sense_check_pkg::*;
#(
  parameter int REPEAT_CYC = REPEAT_GAP_CYC // Repeat-select gap in cycles
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic [8:0] bus_out, // Channel bus out, bit 8 parity
  input wire logic select_out, // Channel tag
  input wire logic address_out, // Channel tag
  input wire logic command_out, // Channel tag
  input wire logic service_out, // Channel tag
  input wire logic operational_in, // Operational in from adapters
  input wire logic [8:0] bus_in_adp, // Bus in from adapter, bit 8 parity
  input wire logic address_in, // Address in tag active
  input wire logic status_in, // Status in tag active
  input wire logic service_in, // Service in tag active
  input wire logic status_accepted, // Channel accepted our status byte
  input wire logic [1:0] addr_jumper, // Address selection jumpers
  input wire logic [3:0] test_in_raw, // Test in 1,2 and misc pins
  input wire logic test_mode, // Adapters in test mode
  input wire logic prio_request, // Priority request serviced
  input wire logic [7:0] prio_response, // Priority response lines
  input wire logic adapter_selected, // An adapter was selected
  input wire logic scan_pulse, // Scan pulse (same clock)
  input wire logic hold_pulse, // Transfer-to-hold pulse
  input wire logic [9:0] config_control_register, // State, assignments, parity
  input wire logic over_temperature_condition, // Temperature out of tolerance
  input wire logic test_switch, // Maintenance test switch
  input wire logic if_disable_switch, // Interface disable switch
  input wire logic repeat_select_sw, // Repeat select switch
  input wire logic execute_select_pb, // Manual select start
  input wire logic select_done, // Manual select cycle completed
  input wire logic cmd_out_stop_pb, // Command-out stop control
  output logic [8:0] bus_in, // Bus in to channel, bit 8 parity
  output logic [7:0] status_byte, // Status byte presented
  output logic [3:0] test_out_lines, // Test out lines
  output logic addr_match, // Address accepted
  output logic attention, // Attention status
  output logic manual_enable, // Manual controls honoured
  output logic manual_select_go, // Start of a manual select cycle
  output logic adapter_stop, // Stop selected adapter
  output logic adapter_halt, // Halt selected adapter
  output logic [8:0] sense1, // Sense byte 1 with parity
  output logic [8:0] sense2, // Sense byte 2 with parity
  output logic [8:0] sense3 // Sense byte 3 with parity
);
  // ----------------------------------------
  // Synchronised pin inputs
  // ----------------------------------------
  logic [3:0] test_in; // Test in lines, synced
  sync2 #(.W(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(test_in_raw),
    .q(test_in)
  );

  typedef enum logic [1:0] {
    SN_IDLE = 2'b00, // Waiting for sense
    SN_SEND = 2'b01 // Transferring bytes
  } sense_e;

  logic [7:0] s1_reg, s1_next; // Sense byte 1 data
  logic [7:0] s2_reg, s2_next; // Sense byte 2 data
  logic [7:0] s3_reg, s3_next; // Sense byte 3 data
  logic [3:0] tol_reg, tol_next; // Test out lines
  logic uc_reg, uc_next; // Unit check
  logic attn_reg, attn_next; // Attention
  logic end_reg, end_next; // Channel and device end
  logic scan_last_reg, scan_last_next; // Last pulse was scan
  logic seen_reg, seen_next; // Any scan/hold pulse seen
  logic cmd_phase_reg, cmd_phase_next; // Command out up to address in fall
  logic svc_in_seen_reg, svc_in_seen_next; // Service in sent to channel
  logic stop_reg, stop_next; // Adapter stop
  sense_e sn_reg, sn_next; // Sense transfer state
  logic [1:0] idx_reg, idx_next; // Sense byte index
  logic [8:0] bus_in_reg, bus_in_next; // Registered bus in
  logic [15:0] gap_reg, gap_next; // Repeat select counter
  logic rpt_wait_reg, rpt_wait_next; // Waiting in repeat gap
  logic go_reg, go_next; // Manual select pulse

  logic [7:0] my_addr; // Jumper address
  logic addr_ok, cmd_ok, data_ok, bin_ok; // Odd parity results
  logic halt_req; // Halt from channel
  logic tags_multi; // Two outbound tags
  logic cmd_defined; // Known command
  logic cmd_strobe; // Command taken
  logic [7:0] new2, new3; // Common faults raised this cycle
  logic [2:0] tag_count; // Outbound tags active

  // ----------------------------------------
  // Decodes
  // ----------------------------------------
  always_comb begin
    // Jumper address choice
    // Address by jumpers
    case (addr_jumper)
      2'b00: my_addr = ADDR_JUMPER0;
      2'b01: my_addr = ADDR_JUMPER1;
      default: my_addr = ADDR_JUMPER2;
    endcase
    addr_ok = ^bus_out;
    cmd_ok = ^bus_out;
    data_ok = ^bus_out;
    bin_ok = ^bus_in_adp;
    // Select out is held through a whole selection, so it is not counted as a tag
    tag_count = 3'({2'b00, address_out} + {2'b00, command_out} + {2'b00, service_out});
    tags_multi = tag_count > 3'd1;
    halt_req = address_out && operational_in && !select_out;
    cmd_strobe = command_out && cmd_phase_reg == 1'b0;
    case (bus_out[7:0])
      CMD_SENSE, CMD_TOL1, CMD_TOL2, CMD_TOL3, CMD_TOL4, CMD_TOL_RESET,
      CMD_RTOL1, CMD_RTOL2, CMD_RTOL3, CMD_RTOL4, CMD_TEST_IO: cmd_defined = 1'b1;
      default: cmd_defined = 1'b0;
    endcase
  end

  assign addr_match = select_out && address_out && addr_ok && bus_out[7:0] == my_addr;
  assign manual_enable = (config_control_register[1:0] == 2'(MANUAL_STATE_ZERO))
    && (test_switch || if_disable_switch);

  // ----------------------------------------
  // Sense, status and control next state
  // ----------------------------------------
  always_comb begin
    new2 = 8'h00;
    new3 = 8'h00;
    s1_next = s1_reg;
    tol_next = tol_reg;
    uc_next = uc_reg;
    end_next = end_reg;
    scan_last_next = scan_last_reg;
    seen_next = seen_reg;
    cmd_phase_next = cmd_phase_reg;
    svc_in_seen_next = svc_in_seen_reg;
    stop_next = stop_reg;
    sn_next = sn_reg;
    idx_next = idx_reg;
    bus_in_next = bus_in_adp;
    if (prio_request && !$onehot0(prio_response)) new2[B2_MULTI_RESP] = 1'b1;
    if (prio_request && !adapter_selected) begin
      new2[B2_SINGLE_RESP] = 1'b1;
      new2[B2_XFER] = 1'b1;
    end
    if (scan_pulse || hold_pulse) begin
      if (seen_reg && scan_pulse == scan_last_reg) new2[B2_SCAN] = 1'b1;
      seen_next = 1'b1;
      scan_last_next = scan_pulse;
    end
    if (|new2[B2_SCAN:B2_MULTI_RESP]) new2[B2_CHECK_STOP] = 1'b1;
    if (!(^config_control_register)) new2[B2_CONFIG] = 1'b1;
    if (tags_multi) new2[B2_TAG] = 1'b1;
    if (select_out && address_out && !addr_ok) new3[B3_ADDR_OUT] = 1'b1;
    if (command_out) cmd_phase_next = 1'b1;
    else if (!address_in) cmd_phase_next = 1'b0;
    // Released bus after command out is not a command byte unless address in still stands
    if ((command_out || (cmd_phase_reg && address_in)) && !cmd_ok) begin
      new3[B3_CMD_OUT] = 1'b1;
      s1_next[B1_BUS_OUT] = 1'b1;
    end
    // Data out parity, byte still forwarded
    if (service_out && !data_ok) new3[B3_SVC_OUT] = 1'b1;
    if (address_in && !bin_ok) new3[B3_ADDR_IN] = 1'b1;
    if (status_in && !bin_ok) new3[B3_STAT_IN] = 1'b1;
    if (service_in && !bin_ok) new3[B3_SVC_IN] = 1'b1;
    if (over_temperature_condition) new3[B3_OTC] = 1'b1;
    // Command decode during initial selection
    if (cmd_strobe) begin
      end_next = 1'b1;
      if (!cmd_ok) s1_next[B1_BUS_OUT] = 1'b1;
      else if (!cmd_defined) s1_next[B1_CMD_REJECT] = 1'b1;
      else begin
        case (bus_out[7:0])
          CMD_TOL1: tol_next[0] = 1'b1;
          CMD_TOL2: tol_next[1] = 1'b1;
          CMD_TOL3: tol_next[2] = 1'b1;
          CMD_TOL4: tol_next[3] = 1'b1;
          CMD_RTOL1: tol_next[0] = 1'b0;
          CMD_RTOL2: tol_next[1] = 1'b0;
          CMD_RTOL3: tol_next[2] = 1'b0;
          CMD_RTOL4: tol_next[3] = 1'b0;
          CMD_TOL_RESET: tol_next = 4'h0;
          CMD_SENSE: begin
            sn_next = SN_SEND;
            idx_next = 2'd0;
            bus_in_next = sense1;
          end
          default: tol_next = tol_reg;
        endcase
      end
    end
    s1_next[B1_TEST_OUT] = &tol_next;
    if (test_mode) begin
      s1_next[B1_TEST_IN1] = test_in[0];
      s1_next[B1_TEST_IN2] = test_in[1];
    end
    case (sn_reg)
      SN_IDLE: idx_next = idx_next;
      SN_SEND: begin
        // Hold the byte on offer until service out takes it
        bus_in_next = idx_reg == 2'd0 ? sense1 : (idx_reg == 2'd1 ? sense2 : sense3);
        if (service_out) begin
          if (idx_reg == 2'd2) begin
            sn_next = SN_IDLE;
            end_next = 1'b1;
          end else begin
            idx_next = 2'(idx_reg + 2'd1);
            bus_in_next = idx_reg == 2'd0 ? sense2 : sense3;
          end
        end
      end
      default: sn_next = SN_IDLE;
    endcase
    s2_next = s2_reg | new2;
    s3_next = s3_reg | new3;
    if (sn_reg == SN_SEND && service_out && idx_reg == 2'd2) begin
      s1_next = SENSE_RESET;
      s2_next = new2;
      s3_next = new3;
      // Test-out bit follows the lines, which a sense does not reset
      s1_next[B1_TEST_OUT] = &tol_next;
    end
    // Unit check set only as a check bit newly sets
    if ((s1_next[B1_CMD_REJECT] && !s1_reg[B1_CMD_REJECT])
      || (s1_next[B1_BUS_OUT] && !s1_reg[B1_BUS_OUT])) uc_next = 1'b1;
    else if (status_accepted) uc_next = 1'b0;
    if (status_accepted && !cmd_strobe) end_next = 1'b0;
    // Attention from common faults, not address out
    attn_next = attn_reg;
    if (|new2 || |new3[B3_OTC:B3_CMD_OUT]) attn_next = 1'b1;
    else if (status_accepted) attn_next = 1'b0;
    if (service_in) svc_in_seen_next = 1'b1;
    if (cmd_out_stop_pb && manual_enable && svc_in_seen_reg && command_out) begin
      stop_next = 1'b1;
      svc_in_seen_next = 1'b0;
    end else if (!cmd_out_stop_pb) stop_next = 1'b0;
  end

  // ----------------------------------------
  // Repeat select timer
  // ----------------------------------------
  always_comb begin
    gap_next = gap_reg;
    rpt_wait_next = rpt_wait_reg;
    go_next = 1'b0;
    if (manual_enable && execute_select_pb && !rpt_wait_reg) go_next = 1'b1;
    if (manual_enable && repeat_select_sw) begin
      if (select_done) begin
        rpt_wait_next = 1'b1;
        gap_next = 16'(REPEAT_CYC - 1);
      end else if (rpt_wait_reg) begin
        if (gap_reg == 16'h0000) begin
          rpt_wait_next = 1'b0;
          go_next = 1'b1;
        end else gap_next = 16'(gap_reg - 16'h0001);
      end
    end else rpt_wait_next = 1'b0;
  end

  // ----------------------------------------
  // State registers; halt keeps config (an input)
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= SENSE_RESET;
      s2_reg <= SENSE_RESET;
      s3_reg <= SENSE_RESET;
      tol_reg <= 4'h0;
      uc_reg <= 1'b0;
      attn_reg <= 1'b0;
      end_reg <= 1'b0;
      scan_last_reg <= 1'b0;
      seen_reg <= 1'b0;
      cmd_phase_reg <= 1'b0;
      svc_in_seen_reg <= 1'b0;
      stop_reg <= 1'b0;
      sn_reg <= SN_IDLE;
      idx_reg <= 2'd0;
      bus_in_reg <= 9'h000;
      gap_reg <= 16'h0000;
      rpt_wait_reg <= 1'b0;
      go_reg <= 1'b0;
    end else if (halt_req) begin
      s1_reg <= SENSE_RESET;
      s2_reg <= SENSE_RESET;
      s3_reg <= SENSE_RESET;
      tol_reg <= 4'h0;
      uc_reg <= 1'b0;
      attn_reg <= 1'b0;
      end_reg <= 1'b0;
      scan_last_reg <= 1'b0;
      seen_reg <= 1'b0;
      cmd_phase_reg <= 1'b0;
      svc_in_seen_reg <= 1'b0;
      stop_reg <= 1'b0;
      sn_reg <= SN_IDLE;
      idx_reg <= 2'd0;
      bus_in_reg <= bus_in_next;
      gap_reg <= 16'h0000;
      rpt_wait_reg <= 1'b0;
      go_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      tol_reg <= tol_next;
      uc_reg <= uc_next;
      attn_reg <= attn_next;
      end_reg <= end_next;
      scan_last_reg <= scan_last_next;
      seen_reg <= seen_next;
      cmd_phase_reg <= cmd_phase_next;
      svc_in_seen_reg <= svc_in_seen_next;
      stop_reg <= stop_next;
      sn_reg <= sn_next;
      idx_reg <= idx_next;
      bus_in_reg <= bus_in_next;
      gap_reg <= gap_next;
      rpt_wait_reg <= rpt_wait_next;
      go_reg <= go_next;
    end
  end

  // ----------------------------------------
  // Outputs; parity bit 8 makes each sense byte odd, bit 0 does so for the status byte
  // ----------------------------------------
  assign sense1 = {~^s1_reg, s1_reg};
  assign sense2 = {~^s2_reg, s2_reg};
  assign sense3 = {~^s3_reg, s3_reg};
  assign bus_in = bus_in_reg;
  assign test_out_lines = tol_reg;
  assign attention = attn_reg;
  assign adapter_stop = stop_reg;
  assign adapter_halt = halt_req;
  assign manual_select_go = go_reg;
  assign status_byte = {1'b0, uc_reg, end_reg, end_reg, 2'b00, attn_reg,
    ~^{uc_reg, end_reg, end_reg, attn_reg}};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tag_check;
    @(posedge clk) disable iff (rst) (tags_multi && !halt_req) |=> s2_reg[B2_TAG];
  endproperty
  a_tag_check: assert property (p_tag_check) else $error("tag check not set");
  property p_addr_no_attn;
    @(posedge clk) disable iff (rst)
      (new3 == 8'h01 && new2 == 8'h00 && !attn_reg) |=> !attn_reg;
  endproperty
  a_addr_no_attn: assert property (p_addr_no_attn) else $error("address check raised attention");
  property p_otc;
    @(posedge clk) disable iff (rst) (over_temperature_condition && !halt_req)
      |=> s3_reg[B3_OTC] && attn_reg;
  endproperty
  a_otc: assert property (p_otc) else $error("temperature flag missing");
  property p_tol_all;
    @(posedge clk) disable iff (rst) s1_reg[B1_TEST_OUT] == (&tol_reg);
  endproperty
  a_tol_all: assert property (p_tol_all) else $error("test-out sense bit wrong");
  property p_halt;
    @(posedge clk) disable iff (rst) halt_req |=> s2_reg == 8'h00 || $past(|new2) == 1'b0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not clear");
  property p_check_stop;
    @(posedge clk) disable iff (rst) (prio_request && !adapter_selected && !halt_req)
      |=> s2_reg[B2_CHECK_STOP] && s2_reg[B2_XFER];
  endproperty
  a_check_stop: assert property (p_check_stop) else $error("check stop missing");
  property p_parity;
    @(posedge clk) disable iff (rst) ^sense1 && ^sense2 && ^sense3;
  endproperty
  a_parity: assert property (p_parity) else $error("sense parity not odd");
  property p_manual;
    @(posedge clk) disable iff (rst) !manual_enable |=> !stop_reg || $past(stop_reg);
  endproperty
  a_manual: assert property (p_manual) else $error("stop without manual enable");
endmodule // adapter_sense_check_monitor

// file: src/sense_check_pkg.sv
// Constants shared by the sense and check logic of the test and monitor adapter
// How it works
// - Status accepted clears unit check
// - Sense completion clears the sense bytes except the test-out bit
// - Undefined good-parity command sets command reject
// - Bad command parity sets bus-out check
// - All four test-out lines set bit
// - Test-in lines reported in test mode
// - Priority malfunction sets check stop
// - Multiple priority responses set check
// - No adapter selected sets bits 2,3
// - Scan and hold pulses must alternate
// - Config register bad parity sets check
// - Two outbound tags set tag check
// - Bad address parity rejected, no attention
// - Bad command parity sets command-out check
// - Bad data parity flagged, still forwarded
// - Bus In parity checked per tag
// - Over temperature sets its bit
// - Adapter answers one of three addresses
// - Manual controls need state 0, test/disable
// - Repeat select restarts after 15 us
// - Command-out stop stops selected adapter
// - Halt resets common logic, keeps config
// - Common faults raise attention except address-out
// - Unit check reported in status bit 6
package sense_check_pkg;
  // ----------------------------------------
  // Bit positions within the sense bytes
  // ----------------------------------------
  localparam int B1_CMD_REJECT = 0;
  localparam int B1_BUS_OUT = 2;
  localparam int B1_TEST_OUT = 5;
  localparam int B1_TEST_IN1 = 6;
  localparam int B1_TEST_IN2 = 7;
  localparam int B2_CHECK_STOP = 0;
  localparam int B2_MULTI_RESP = 1;
  localparam int B2_SINGLE_RESP = 2;
  localparam int B2_XFER = 3;
  localparam int B2_SCAN = 4;
  localparam int B2_CONFIG = 5;
  localparam int B2_TAG = 6;
  localparam int B3_ADDR_OUT = 0;
  localparam int B3_CMD_OUT = 1;
  localparam int B3_SVC_OUT = 2;
  localparam int B3_ADDR_IN = 3;
  localparam int B3_STAT_IN = 4;
  localparam int B3_SVC_IN = 5;
  localparam int B3_OTC = 6;
  // ----------------------------------------
  // Status byte bits (bit 0 of the byte carries parity)
  // ----------------------------------------
  localparam int ST_ATTENTION = 1;
  localparam int ST_CHAN_END = 4;
  localparam int ST_DEV_END = 5;
  localparam int ST_UNIT_CHECK = 6;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SENSE_RESET = 8'h00;
  // ----------------------------------------
  // Adapter addresses per jumper setting
  // ----------------------------------------
  localparam logic [7:0] ADDR_JUMPER0 = 8'h10; // 16
  localparam logic [7:0] ADDR_JUMPER1 = 8'h60; // 96
  localparam logic [7:0] ADDR_JUMPER2 = 8'hb0; // 176
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_SENSE = 8'h04;
  localparam logic [7:0] CMD_TOL1 = 8'h0b;
  localparam logic [7:0] CMD_TOL2 = 8'h1b;
  localparam logic [7:0] CMD_TOL3 = 8'h23;
  localparam logic [7:0] CMD_TOL4 = 8'h2b;
  localparam logic [7:0] CMD_TOL_RESET = 8'h33;
  localparam logic [7:0] CMD_RTOL1 = 8'hcb;
  localparam logic [7:0] CMD_RTOL2 = 8'hdb;
  localparam logic [7:0] CMD_RTOL3 = 8'he3;
  localparam logic [7:0] CMD_RTOL4 = 8'heb;
  localparam logic [7:0] CMD_TEST_IO = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int REPEAT_GAP_US = 15;
  localparam int REPEAT_GAP_CYC = (REPEAT_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MANUAL_STATE_ZERO = 0;
endpackage

// file: src/sync2.sv
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1 // Width of the level bundle
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta_reg; // First stage, read by second only
  // ----------------------------------------
  // Two registered stages
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // sync2

// file: dv/chan_model.sv
// Behavioural multiplexor channel driving the outbound tags and bus
`timescale 1ns/1ps
module chan_model (
  input wire logic clk, // System clock
  output logic [8:0] bus_out, // Bus out, bit 8 parity
  output logic select_out, // Select tag
  output logic address_out, // Address tag
  output logic command_out, // Command tag
  output logic service_out, // Service tag
  output logic status_accepted // Status taken pulse
);
  initial begin
    {select_out, address_out, command_out, service_out, status_accepted} = 5'h00;
    bus_out = 9'h100;
  end
  // ----------------------------------------
  // Tag and bus driving
  // ----------------------------------------
  // Tags as commanded
  task automatic put(input logic [3:0] t, input logic [8:0] d);
    {select_out, address_out, command_out, service_out} = t;
    // Released bus shows the inverse, never a stale byte
    bus_out = (t == 4'h0) ? ~bus_out : d;
  endtask
  task automatic ack();
    status_accepted = 1'b1;
    @(posedge clk);
    #1 status_accepted = 1'b0;
  endtask
endmodule // chan_model

// file: dv/adapter_sense_check_monitor_tb.sv
// Self-checking bench for the sense and check logic
`timescale 1ns/1ps
module adapter_sense_check_monitor_tb;
  import sense_check_pkg::*;
  logic clk = 1'b0, rst = 1'b1; // Clock and reset
  wire logic [8:0] bus_out; // From channel model
  wire logic select_out, address_out, command_out, service_out, status_accepted;
  logic operational_in = 1'b0, address_in = 1'b0, status_in = 1'b0, service_in = 1'b0;
  logic [8:0] bus_in_adp = 9'h100; // Adapter byte
  logic [1:0] addr_jumper = 2'h0; // Jumpers
  logic [3:0] test_in_raw = 4'h0; // Test in pins
  logic test_mode = 1'b0, prio_request = 1'b0, adapter_selected = 1'b1;
  logic [7:0] prio_response = 8'h00; // Priority lines
  logic scan_pulse = 1'b0, hold_pulse = 1'b0, over_temperature_condition = 1'b0;
  // Good odd parity, state 0
  logic [9:0] config_control_register = 10'h200;
  logic test_switch = 1'b0, if_disable_switch = 1'b0, repeat_select_sw = 1'b0;
  logic execute_select_pb = 1'b0, select_done = 1'b0, cmd_out_stop_pb = 1'b0;
  logic [8:0] bus_in, sense1, sense2, sense3; // Design outputs
  logic [7:0] status_byte; // Status byte
  logic [3:0] test_out_lines; // Test out lines
  logic addr_match, attention, manual_enable, manual_select_go, adapter_stop, adapter_halt;
  int fail_count = 0, checks = 0; // Tallies
  logic [7:0] adr [3] = '{ADDR_JUMPER0, ADDR_JUMPER1, ADDR_JUMPER2};
  logic [7:0] tol [4] = '{CMD_TOL1, CMD_TOL2, CMD_TOL3, CMD_TOL4};
  always #50 clk = ~clk;
  adapter_sense_check_monitor #(.REPEAT_CYC(5)) i_dut (.*);
  chan_model i_chan (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [8:0] par(input logic [7:0] v);
    return {~^v, v};
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  // Address then command, bus left driven with command out up
  task automatic cmd(input logic [8:0] c);
    step();
    i_chan.put(4'hc, par(ADDR_JUMPER0));
    step();
    i_chan.put(4'ha, c);
    step();
  endtask
  // Halt clears common state
  task automatic halt();
    operational_in = 1'b1;
    i_chan.put(4'h4, 9'h100);
    #1 chk("halt", 9'h001, {8'h00, adapter_halt});
    step();
    operational_in = 1'b0;
    i_chan.put(4'h0, 9'h0);
    chk("s1", 9'h100, sense1);
    chk("s2", 9'h100, sense2);
    chk("s3", 9'h100, sense3);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk("s1", 9'h100, sense1);
    chk("st", 9'h001, {1'b0, status_byte});
    for (int j = 0; j < 3; j++) begin
      addr_jumper = 2'(j);
      i_chan.put(4'hc, par(adr[j]));
      #1 chk("match", 9'h001, {8'h00, addr_match});
      step();
    end
    addr_jumper = 2'h0;
    i_chan.put(4'hc, par(ADDR_JUMPER0) ^ 9'h100);
    #1 chk("match", 9'h000, {8'h00, addr_match});
    step();
    i_chan.put(4'h0, 9'h0);
    chk("s3", 9'h001, sense3);
    chk("attn", 9'h000, {8'h00, attention});
    $display("test address done");
    cmd(par(CMD_SENSE));
    chk("byte1", 9'h100, bus_in);
    i_chan.put(4'h9, 9'h100);
    step();
    chk("byte2", 9'h100, bus_in);
    step();
    chk("byte3", 9'h001, bus_in);
    step();
    i_chan.put(4'h0, 9'h0);
    chk("s3", 9'h100, sense3);
    chk("st", 9'h031, {1'b0, status_byte});
    $display("test sense done");
    cmd(par(CMD_TEST_IO) ^ 9'h100);
    i_chan.put(4'h0, 9'h0);
    step();
    chk("s1", 9'h004, sense1);
    chk("s3", 9'h002, sense3);
    chk("uc", 9'h001, {8'h00, status_byte[ST_UNIT_CHECK]});
    i_chan.ack();
    step();
    chk("uc", 9'h000, {8'h00, status_byte[ST_UNIT_CHECK]});
    halt();
    cmd(par(8'hff));
    i_chan.put(4'h0, 9'h0);
    step();
    chk("s1", 9'h001, sense1);
    halt();
    $display("test command done");
    i_chan.put(4'h6, 9'h100);
    step();
    i_chan.put(4'h0, 9'h0);
    step();
    chk("s2", 9'h040, sense2);
    chk("attn", 9'h001, {8'h00, attention});
    halt();
    {prio_request, prio_response, over_temperature_condition} = {1'b1, 8'h03, 1'b1};
    adapter_selected = 1'b0;
    {address_in, bus_in_adp} = {1'b1, 9'h0a5};
    step();
    chk("fwd", 9'h0a5, bus_in);
    {prio_request, prio_response, over_temperature_condition} = 10'h000;
    adapter_selected = 1'b1;
    {address_in, bus_in_adp} = {1'b0, 9'h100};
    step();
    step();
    chk("s2", 9'h10f, sense2);
    chk("s3", 9'h148, sense3);
    halt();
    $display("test faults done");
    for (int j = 0; j < 4; j++) begin
      cmd(par(tol[j]));
      i_chan.put(4'h0, 9'h0);
      step();
    end
    chk("tol", 9'h00f, {5'h00, test_out_lines});
    {test_mode, test_in_raw} = {1'b1, 4'h3};
    repeat (4) step();
    chk("s1", 9'h0e0, sense1);
    $display("test lines done");
    test_switch = 1'b1;
    #1 chk("man", 9'h001, {8'h00, manual_enable});
    execute_select_pb = 1'b1;
    step();
    execute_select_pb = 1'b0;
    chk("go", 9'h001, {8'h00, manual_select_go});
    {repeat_select_sw, select_done} = 2'b11;
    step();
    select_done = 1'b0;
    repeat (4) step();
    chk("go", 9'h000, {8'h00, manual_select_go});
    step();
    chk("go", 9'h001, {8'h00, manual_select_go});
    repeat_select_sw = 1'b0;
    service_in = 1'b1;
    step();
    {service_in, cmd_out_stop_pb} = 2'b01;
    i_chan.put(4'h2, par(CMD_TEST_IO));
    step();
    chk("stop", 9'h001, {8'h00, adapter_stop});
    i_chan.put(4'h0, 9'h0);
    cmd_out_stop_pb = 1'b0;
    step();
    chk("stop", 9'h000, {8'h00, adapter_stop});
    $display("test manual done");
    finish_test();
  end
endmodule // adapter_sense_check_monitor_tb
